// file: rtl/csdd_host.sv
`timescale 1ns/1ps
module csdd_host
	import csdd_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic ce_in,
	// Link to the card
	csdd_link_if.ctrl link,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	output logic [1:0]       s_axi_bresp_out,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	input  wire logic [7:0]  s_axi_araddr_in,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out
);
	import csdd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b001,
		HOST_REQ  = 3'b010,
		HOST_WAIT = 3'b100
	} csdd_host_fsm_type;

	typedef struct packed {
		csdd_host_fsm_type fsm;
		logic              aw_got;
		logic [7:0]        aw_addr;
		logic              w_got;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [2:0]        op;
		logic [31:0]       arg_a;
		logic [31:0]       arg_b;
		logic [REC_W-1:0]  stage;
		logic [REC_W-1:0]  req_rec;
		logic              done;
		csdd_stat_type     stat;
		logic [31:0]       first;
		logic [31:0]       last;
	} csdd_host_state_type;

	csdd_host_state_type s;
	csdd_host_state_type next_s;

	logic [3:0]  rbl;
	logic        invalid;
	logic [31:0] fact;
	logic [31:0] geo;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [1:0]  widx;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] m);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (m[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Record decode
	// ----------------------------------------------------------------
	always_comb begin
		rbl     = s.stage[RBL_LSB +: BL_W];
		invalid = (rbl < BL_MIN) || (rbl > BL_MAX)
			|| (s.stage[WBL_LSB +: BL_W] != rbl)
			|| (s.stage[R2W_LSB +: CUR_W] > R2W_MAX)
			|| s.stage[FFG_BIT];
		fact    = 32'h0000_0000;
		// Exponent sum needs four bits: code 7 plus bias 2 reaches 9
		fact[9:0]   = 10'(10'h001 << (4'(s.stage[SIZE_SCALE_FACTOR_LSB +: CUR_W]) + 4'(SIZE_SCALE_FACTOR_BIAS)));
		fact[21:16] = 6'(6'h01 << s.stage[R2W_LSB +: CUR_W]);
		geo     = 32'h0000_0000;
		geo[7:0]    = 8'(s.stage[SECT_LSB +: CNT7_W]) + 8'h01;
		geo[15:8]   = 8'(s.stage[GRP_LSB +: CNT7_W]) + 8'h01;
		geo[27:16]  = 12'(12'h001 << rbl);
		geo[29:28]  = s.stage[FF_LSB +: FF_W];
		geo[30]     = s.stage[WMIS_BIT];
		geo[31]     = s.stage[RMIS_BIT];
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr_in >= OFS_REC0 && s_axi_araddr_in <= OFS_REC3)
			rd_word = s.stage[32*(s_axi_araddr_in[3:2]) +: 32];
		else
			unique case (s_axi_araddr_in)
				OFS_CTRL:   rd_word = {28'h000_0000, s.op, 1'b0};
				OFS_ARG_A:  rd_word = s.arg_a;
				OFS_ARG_B:  rd_word = s.arg_b;
				OFS_STATUS: rd_word = {25'h000_0000, s.stat, 1'b0, invalid, s.done,
					(s.fsm != HOST_IDLE)};
				OFS_FIRST:  rd_word = s.first;
				OFS_LAST:   rd_word = s.last;
				OFS_CAP:    rd_word = csdd_cap_sectors(s.stage);
				OFS_FACT:   rd_word = fact;
				OFS_GEO:    rd_word = geo;
				default:    rd_hit = 1'b0;
			endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		widx   = s.aw_addr[3:2];
		// Address and data are caught separately, in either order
		if (s_axi_awvalid_in && !s.aw_got && !s.bvalid) begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !s.w_got && !s.bvalid) begin
			next_s.w_got  = 1'b1;
			next_s.w_data = s_axi_wdata_in;
			next_s.w_strb = s_axi_wstrb_in;
		end
		if (s.bvalid && s_axi_bready_in)
			next_s.bvalid = 1'b0;
		if (s.rvalid && s_axi_rready_in)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid_in && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_hit ? rd_word : 32'h0000_0000;
			next_s.rresp  = rd_hit ? RESP_OKAY : RESP_SLV;
		end
		// Register write once both halves are held
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			if (s.aw_addr >= OFS_REC0 && s.aw_addr <= OFS_REC3)
				next_s.stage[32*widx +: 32] = wmerge(s.stage[32*widx +: 32], s.w_data,
					s.w_strb);
			else
				unique case (s.aw_addr)
					OFS_CTRL: begin
						if (s.w_strb[0]) begin
							next_s.op = s.w_data[3:1];
							// Start ignored while a command is under way
							if (s.w_data[0] && s.fsm == HOST_IDLE) begin
								next_s.fsm     = HOST_REQ;
								next_s.req_rec = csdd_seal(s.stage);
							end
						end
					end
					OFS_ARG_A:  next_s.arg_a = wmerge(s.arg_a, s.w_data, s.w_strb);
					OFS_ARG_B:  next_s.arg_b = wmerge(s.arg_b, s.w_data, s.w_strb);
					OFS_STATUS: begin
						if (s.w_strb[0] && s.w_data[1])
							next_s.done = 1'b0;
					end
					default:    next_s.bresp = RESP_SLV;
				endcase
		end
		unique case (s.fsm)
			HOST_IDLE: begin
			end
			HOST_REQ: begin
				if (link.req_ready)
					next_s.fsm = HOST_WAIT;
			end
			HOST_WAIT: begin
				// Completion set beats a same-cycle software clear
				if (link.rsp_valid) begin
					next_s.fsm   = HOST_IDLE;
					next_s.done  = 1'b1;
					next_s.stat  = link.rsp_status;
					next_s.stage = link.rsp_rec;
					next_s.first = link.rsp_first;
					next_s.last  = link.rsp_last;
				end
			end
			default: begin
				next_s.fsm = HOST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			s <= '{fsm: HOST_IDLE, stat: STAT_OK, default: '0};
		else if (ce_in)
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_out = !s.aw_got && !s.bvalid;
	assign s_axi_wready_out  = !s.w_got && !s.bvalid;
	assign s_axi_bvalid_out  = s.bvalid;
	assign s_axi_bresp_out   = s.bresp;
	assign s_axi_arready_out = !s.rvalid;
	assign s_axi_rvalid_out  = s.rvalid;
	assign s_axi_rdata_out   = s.rdata;
	assign s_axi_rresp_out   = s.rresp;
	assign link.req_valid    = (s.fsm == HOST_REQ);
	assign link.req_op       = csdd_op_type'(s.op);
	assign link.req_arg_a    = s.arg_a;
	assign link.req_arg_b    = s.arg_b;
	assign link.req_rec      = s.req_rec;

endmodule // csdd_host

// file: rtl/csdd_pkg.sv
package csdd_pkg;

	// ----------------------------------------------------------------
	// Record layout
	// ----------------------------------------------------------------
	localparam int REC_W      = 128;
	localparam int RBL_LSB    = 80;
	localparam int RPART_BIT  = 79;
	localparam int WMIS_BIT   = 78;
	localparam int RMIS_BIT   = 77;
	localparam int DSR_BIT    = 76;
	localparam int CSIZE_LSB  = 62;
	localparam int RCL_LSB    = 59;
	localparam int RCH_LSB    = 56;
	localparam int WCL_LSB    = 53;
	localparam int WCH_LSB    = 50;
	localparam int SIZE_SCALE_FACTOR_LSB   = 47;
	localparam int ERBLK_BIT  = 46;
	localparam int SECT_LSB   = 39;
	localparam int GRP_LSB    = 32;
	localparam int GRPEN_BIT  = 31;
	localparam int R2W_LSB    = 26;
	localparam int WBL_LSB    = 22;
	localparam int WPART_BIT  = 21;
	localparam int FFG_BIT    = 15;
	localparam int COPY_BIT   = 14;
	localparam int PERM_BIT   = 13;
	localparam int TMP_BIT    = 12;
	localparam int FF_LSB     = 10;
	localparam int CRC_LSB    = 1;
	localparam int CRC_TOP    = 8;
	localparam int END_BIT    = 0;
	localparam int BL_W       = 4;
	localparam int CUR_W      = 3;
	localparam int CSIZE_W    = 12;
	localparam int CNT7_W     = 7;
	localparam int FF_W       = 2;

	// ----------------------------------------------------------------
	// Codes and limits
	// ----------------------------------------------------------------
	localparam logic [3:0]  BL_MIN      = 4'h9;
	localparam logic [3:0]  BL_1K       = 4'hA;
	localparam logic [3:0]  BL_MAX      = 4'hB;
	localparam logic [2:0]  R2W_MAX     = 3'h5;
	localparam logic [4:0]  SIZE_SCALE_FACTOR_BIAS   = 5'h02;
	localparam int          UNIT_SH     = 9;
	localparam logic [31:0] SECT_LIMIT  = 32'h003F_6000;
	localparam logic [31:0] ONE_GB_SECT = 32'h0020_0000;
	localparam logic [6:0]  CRC_POLY    = 7'h09;

	// ----------------------------------------------------------------
	// Host register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ARG_A  = 8'h04;
	localparam logic [7:0] OFS_ARG_B  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_REC0   = 8'h10;
	localparam logic [7:0] OFS_REC3   = 8'h1C;
	localparam logic [7:0] OFS_FIRST  = 8'h20;
	localparam logic [7:0] OFS_LAST   = 8'h24;
	localparam logic [7:0] OFS_CAP    = 8'h28;
	localparam logic [7:0] OFS_FACT   = 8'h2C;
	localparam logic [7:0] OFS_GEO    = 8'h30;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;

	typedef enum logic [2:0] {
		OP_GET = 3'h0, OP_PUT = 3'h1, OP_RD = 3'h2,
		OP_WR  = 3'h3, OP_ER  = 3'h4, OP_DSR = 3'h5
	} csdd_op_type;

	typedef enum logic [2:0] {
		STAT_OK = 3'h0, STAT_PROT = 3'h1, STAT_ALIGN = 3'h2, STAT_SIZE = 3'h3,
		STAT_CRC = 3'h4, STAT_NODSR = 3'h5, STAT_BADOP = 3'h6
	} csdd_stat_type;

	// Seven-bit checksum over everything above the checksum field
	function automatic logic [6:0] csdd_crc7(input logic [REC_W-1:0] r);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = REC_W - 1; i >= CRC_TOP; i--) begin
			fb = r[i] ^ c[6];
			c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
		end
		return c;
	endfunction

	function automatic logic [REC_W-1:0] csdd_seal(input logic [REC_W-1:0] r);
		logic [REC_W-1:0] o;
		o = r;
		o[CRC_LSB +: CNT7_W] = csdd_crc7(r);
		o[END_BIT] = 1'b1;
		return o;
	endfunction

	// Capacity in 512-byte sectors, zero for a reserved block length
	function automatic logic [31:0] csdd_cap_sectors(input logic [REC_W-1:0] r);
		logic [3:0] bl;
		logic [4:0] sh;
		bl = r[RBL_LSB +: BL_W];
		sh = 5'(r[SIZE_SCALE_FACTOR_LSB +: CUR_W]) + SIZE_SCALE_FACTOR_BIAS + 5'(bl) - 5'(BL_MIN);
		if (bl < BL_MIN || bl > BL_MAX)
			return 32'h0000_0000;
		return (32'(r[CSIZE_LSB +: CSIZE_W]) + 32'h0000_0001) << sh;
	endfunction

	// Power-on record: 512-byte blocks, small example capacity
	function automatic logic [REC_W-1:0] csdd_default_rec(input logic dsr);
		logic [REC_W-1:0] r;
		r = '0;
		r[RBL_LSB +: BL_W]      = BL_MIN;
		r[RPART_BIT]            = 1'b1;
		r[DSR_BIT]              = dsr;
		r[CSIZE_LSB +: CSIZE_W] = 12'h7D0;
		r[RCL_LSB +: CUR_W]     = 3'h4;
		r[RCH_LSB +: CUR_W]     = 3'h4;
		r[WCL_LSB +: CUR_W]     = 3'h4;
		r[WCH_LSB +: CUR_W]     = 3'h4;
		r[SIZE_SCALE_FACTOR_LSB +: CUR_W]    = 3'h3;
		r[ERBLK_BIT]            = 1'b1;
		r[SECT_LSB +: CNT7_W]   = 7'h1F;
		r[R2W_LSB +: CUR_W]     = 3'h2;
		r[WBL_LSB +: BL_W]      = BL_MIN;
		return csdd_seal(r);
	endfunction

endpackage

// file: rtl/csdd_link_if.sv
`timescale 1ns/1ps
interface csdd_link_if;
	import csdd_pkg::*;

	logic          req_valid;
	logic          req_ready;
	csdd_op_type   req_op;
	logic [31:0]   req_arg_a;
	logic [31:0]   req_arg_b;
	logic [127:0]  req_rec;
	logic          rsp_valid;
	csdd_stat_type rsp_status;
	logic [127:0]  rsp_rec;
	logic [31:0]   rsp_first;
	logic [31:0]   rsp_last;

	modport card (input req_valid, req_op, req_arg_a, req_arg_b, req_rec,
		output req_ready, rsp_valid, rsp_status, rsp_rec, rsp_first, rsp_last);
	modport ctrl (output req_valid, req_op, req_arg_a, req_arg_b, req_rec,
		input req_ready, rsp_valid, rsp_status, rsp_rec, rsp_first, rsp_last);
endinterface

// file: rtl/csdd_card.sv
`timescale 1ns/1ps
module csdd_card
	import csdd_pkg::*;
#(
	parameter logic DSR_PRESENT = 1'b0,
	parameter logic IS_ROM      = 1'b0
) (
	// Clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic ce_in,
	// Link to the controller
	csdd_link_if.card link,
	// User side
	input  wire logic        group_lock_in,
	output logic [15:0]      dsr_out,
	output logic             drive_strength_present_out,
	output logic             perm_protect_out,
	output logic             temp_protect_out,
	output logic             config_fault_out
);
	import csdd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CARD_IDLE   = 2'b01,
		CARD_ANSWER = 2'b10
	} csdd_card_fsm_type;

	typedef struct packed {
		csdd_card_fsm_type fsm;
		logic [REC_W-1:0]  rec;
		logic [15:0]       dsr;
		csdd_stat_type     stat;
		logic [31:0]       first;
		logic [31:0]       last;
		logic              fault;
	} csdd_card_state_type;

	localparam logic [REC_W-1:0] REC_RESET = csdd_default_rec(DSR_PRESENT);

	csdd_card_state_type s;
	csdd_card_state_type next_s;

	logic [3:0]       rbl;
	logic [3:0]       wbl;
	logic [31:0]      a;
	logic [31:0]      b;
	logic [31:0]      end_b;
	logic [31:0]      sect;
	logic [31:0]      cap;
	logic             locked;
	logic [REC_W-1:0] nrec;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Every check answers in the cycle after the take; the divisions
	// for sector rounding are long paths, fine at this slow clock
	always_comb begin
		next_s = s;
		rbl    = s.rec[RBL_LSB +: BL_W];
		wbl    = s.rec[WBL_LSB +: BL_W];
		a      = link.req_arg_a;
		b      = link.req_arg_b;
		end_b  = a + b - 32'h0000_0001;
		sect   = 32'(s.rec[SECT_LSB +: CNT7_W]) + 32'h0000_0001;
		cap    = csdd_cap_sectors(s.rec);
		// Group lock counts only when group protection exists
		locked = s.rec[PERM_BIT] | s.rec[TMP_BIT]
			| (s.rec[GRPEN_BIT] & group_lock_in);
		nrec   = s.rec;
		// Static sanity of the held record
		next_s.fault = (rbl < BL_MIN) || (rbl > BL_MAX)
			|| (wbl != rbl)
			|| (cap > SECT_LIMIT)
			|| ((cap > ONE_GB_SECT) && (rbl != BL_1K))
			|| !s.rec[RPART_BIT]
			|| (s.rec[DSR_BIT] != DSR_PRESENT);
		unique case (s.fsm)
			CARD_IDLE: begin
				if (link.req_valid) begin
					next_s.fsm   = CARD_ANSWER;
					next_s.stat  = STAT_OK;
					next_s.first = a;
					next_s.last  = b;
					case (link.req_op)
						OP_GET: begin
							next_s.stat = STAT_OK;
						end
						OP_RD: begin
							next_s.last = end_b;
							// Any length from one byte up to one read block passes the size check
							if (b == 32'h0000_0000 || b > (32'h0000_0001 << rbl))
								next_s.stat = STAT_SIZE;
							else if (!s.rec[RMIS_BIT] && ((a >> rbl) != (end_b >> rbl)))
								next_s.stat = STAT_ALIGN;
						end
						OP_WR: begin
							next_s.last = end_b;
							if (locked)
								next_s.stat = STAT_PROT;
							else if (b == 32'h0000_0000 || b > (32'h0000_0001 << wbl))
								next_s.stat = STAT_SIZE;
							else if (!s.rec[WPART_BIT] && (b[UNIT_SH-1:0] != '0))
								next_s.stat = STAT_SIZE;
							else if (!s.rec[WMIS_BIT] && ((a >> wbl) != (end_b >> wbl)))
								next_s.stat = STAT_ALIGN;
						end
						OP_ER: begin
							if (locked)
								next_s.stat = STAT_PROT;
							else if (b < a)
								next_s.stat = STAT_SIZE;
							else if (!s.rec[ERBLK_BIT]) begin
								next_s.first = a - (a % sect);
								next_s.last  = b - (b % sect) + sect - 32'h0000_0001;
							end
							// With single-block erase the range stays as given
						end
						OP_PUT: begin
							if (csdd_crc7(link.req_rec) != link.req_rec[CRC_LSB +: CNT7_W]
								|| !link.req_rec[END_BIT]) begin
								next_s.stat = STAT_CRC;
							end else begin
								// One-time bits can only be set, ROM keeps them
								if (!IS_ROM) begin
									nrec[COPY_BIT] = s.rec[COPY_BIT] | link.req_rec[COPY_BIT];
									nrec[PERM_BIT] = s.rec[PERM_BIT] | link.req_rec[PERM_BIT];
									nrec[FFG_BIT]  = link.req_rec[FFG_BIT];
									nrec[FF_LSB +: FF_W] = link.req_rec[FF_LSB +: FF_W];
								end
								nrec[TMP_BIT] = link.req_rec[TMP_BIT];
								// Resealed since a refused bit may differ from the host copy
								next_s.rec = csdd_seal(nrec);
							end
						end
						OP_DSR: begin
							if (DSR_PRESENT)
								next_s.dsr = a[15:0];
							else
								next_s.stat = STAT_NODSR;
						end
						default: begin
							next_s.stat = STAT_BADOP;
						end
					endcase
				end
			end
			CARD_ANSWER: begin
				next_s.fsm = CARD_IDLE;
			end
			default: begin
				next_s.fsm = CARD_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Protect and copy bits fall back to the power-on record at reset;
	// a real card would keep them in non-volatile cells
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s.fsm   <= CARD_IDLE;
			s.rec   <= REC_RESET;
			s.dsr   <= 16'h0000;
			s.stat  <= STAT_OK;
			s.first <= 32'h0000_0000;
			s.last  <= 32'h0000_0000;
			s.fault <= 1'b0;
		end else if (ce_in) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Current class fields pass out untouched inside the record
	assign link.req_ready             = (s.fsm == CARD_IDLE);
	assign link.rsp_valid             = (s.fsm == CARD_ANSWER);
	assign link.rsp_status            = s.stat;
	assign link.rsp_rec               = s.rec;
	assign link.rsp_first             = s.first;
	assign link.rsp_last              = s.last;
	assign dsr_out                    = s.dsr;
	assign drive_strength_present_out = DSR_PRESENT;
	assign perm_protect_out           = s.rec[PERM_BIT];
	assign temp_protect_out           = s.rec[TMP_BIT];
	assign config_fault_out           = s.fault;

endmodule // csdd_card

// file: testbench/csdd_link_props.sv
`timescale 1ns/1ps
module csdd_link_props
	import csdd_pkg::*;
(
	// Clock and reset
	input wire logic          clk_in,
	input wire logic          rst_b_in,
	// Link signals
	input wire logic          req_valid,
	input wire logic          req_ready,
	input wire csdd_op_type   req_op,
	input wire logic [31:0]   req_arg_a,
	input wire logic [31:0]   req_arg_b,
	input wire logic          rsp_valid,
	input wire csdd_stat_type rsp_status,
	input wire logic [127:0]  rsp_rec,
	input wire logic [31:0]   rsp_first,
	input wire logic [31:0]   rsp_last
);
	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// A request counts only on the edge the card is idle
	logic take;
	logic alter;
	assign take  = req_valid && req_ready;
	assign alter = take && (req_op == OP_WR || req_op == OP_ER);

	// -----------------------------------------------------------
	// Properties
	// -----------------------------------------------------------
	answer_next_a: assert property (take |=> rsp_valid)
		else $error("no answer after take");
	answer_pulse_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
		else $error("answer longer than one cycle");
	busy_answer_a: assert property (rsp_valid |-> !req_ready)
		else $error("ready during answer");
	read_partial_a: assert property (rsp_rec[RPART_BIT])
		else $error("read partial flag low");
	block_codes_a: assert property (rsp_rec[WBL_LSB +: BL_W] == rsp_rec[RBL_LSB +: BL_W]
		&& rsp_rec[RBL_LSB +: BL_W] inside {[BL_MIN:BL_MAX]}) else $error("block code bad");
	perm_reject_a: assert property (alter && rsp_rec[PERM_BIT] |=> rsp_status == STAT_PROT)
		else $error("write passed permanent lock");
	temp_reject_a: assert property (alter && rsp_rec[TMP_BIT] |=> rsp_status == STAT_PROT)
		else $error("write passed temporary lock");
	copy_sticky_a: assert property (rsp_rec[COPY_BIT] |=> rsp_rec[COPY_BIT])
		else $error("copy marker cleared");
	perm_sticky_a: assert property (rsp_rec[PERM_BIT] |=> $stable(rsp_rec[PERM_BIT]))
		else $error("permanent lock cleared");
	erase_exact_a: assert property (take && req_op == OP_ER && rsp_rec[ERBLK_BIT]
		|=> rsp_status != STAT_OK || (rsp_first == $past(req_arg_a)
		&& rsp_last == $past(req_arg_b))) else $error("erase range wrong");
	wr_partial_a: assert property (take && req_op == OP_WR && !rsp_rec[WPART_BIT]
		&& rsp_rec[13:12] == 2'b00 && !rsp_rec[GRPEN_BIT] && req_arg_b[8:0] != 9'h000
		|=> rsp_status == STAT_SIZE) else $error("partial write accepted");
	// Main scenarios seen
	cover property (take && req_op == OP_ER);
	cover property (rsp_valid && rsp_status == STAT_PROT);
	cover property (rsp_valid && rsp_status == STAT_ALIGN);
endmodule // csdd_link_props

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import csdd_pkg::*;
	// -----------------------------------------------------------
	// Signals
	// -----------------------------------------------------------
	logic        clk_in   = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        lock     = 1'b0;
	logic        awvalid  = 1'b0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic [7:0]  araddr   = 8'h00;
	logic [31:0] wdata    = 32'h0000_0000;
	logic        awready, wready, bvalid, arready, rvalid, dsp, perm, temp, fault;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [15:0] dsr;
	int          failures = 0;
	int          total_checks = 0;

	csdd_link_if link ();
	csdd_card i_csdd_card (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .link(link),
		.group_lock_in(lock), .dsr_out(dsr), .drive_strength_present_out(dsp),
		.perm_protect_out(perm), .temp_protect_out(temp), .config_fault_out(fault));
	csdd_host i_csdd_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .link(link),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
	csdd_link_props i_csdd_link_props (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.req_valid(link.req_valid), .req_ready(link.req_ready), .req_op(link.req_op),
		.req_arg_a(link.req_arg_a), .req_arg_b(link.req_arg_b), .rsp_valid(link.rsp_valid),
		.rsp_status(link.rsp_status), .rsp_rec(link.rsp_rec), .rsp_first(link.rsp_first),
		.rsp_last(link.rsp_last));

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Readies are sampled mid-cycle, where they already hold their edge value
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ar, wr, bv;
		@(posedge clk_in);
		{awvalid, wvalid, bready} <= 3'b111;
		awaddr <= a;
		wdata <= d;
		do begin
			@(negedge clk_in);
			{ar, wr, bv} = {awready, wready, bvalid};
			rs = bresp;
			@(posedge clk_in);
			if (ar) awvalid <= 1'b0;
			if (wr) wvalid <= 1'b0;
		end while (!bv);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		logic ar, rv;
		@(posedge clk_in);
		{arvalid, rready} <= 2'b11;
		araddr <= a;
		do begin
			@(negedge clk_in);
			{ar, rv} = {arready, rvalid};
			{rd, rs} = {rdata, rresp};
			@(posedge clk_in);
			if (ar) arvalid <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
	endtask
	// One link command through the host; done is polled, then cleared
	task automatic cmd(input csdd_op_type op, input int a, input int b, input csdd_stat_type st);
		axi_wr(OFS_ARG_A, a);
		axi_wr(OFS_ARG_B, b);
		axi_wr(OFS_CTRL, {28'h000_0000, op, 1'b1});
		rd = 32'h0000_0000;
		for (int n = 0; n < 40 && rd[1] !== 1'b1; n++) axi_rd(OFS_STATUS);
		check("done", 32'h1, 32'(rd[1]));
		check("status", {29'h0000_0000, st}, 32'(rd[6:4]));
		axi_wr(OFS_STATUS, 32'h0000_0002);
	endtask
	task automatic complete_run();
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// -----------------------------------------------------------
	// Clock, watchdog and tests
	// -----------------------------------------------------------
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	// Far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			cmd(OP_GET, 0, 0, STAT_OK);
			axi_rd(OFS_REC0);
			check("copy perm temp", 32'h0, 32'(rd[14:12]));
			axi_rd(OFS_CAP);
			check("cap", (32'h0000_07D0 + 32'h0000_0001) << 5, rd);
			if (k == 1) complete_run();
			check("present", 32'h0, 32'(dsp));
			axi_rd(OFS_FACT);
			check("fact", 32'h0004_0020, rd);
			axi_rd(OFS_GEO);
			check("geo", 32'h0200_0120, rd);
			cmd(OP_RD, 0, 0, STAT_SIZE);
			cmd(OP_RD, 0, 513, STAT_SIZE);
			cmd(OP_RD, 500, 20, STAT_ALIGN);
			cmd(OP_RD, 7, 1, STAT_OK);
			cmd(OP_WR, 0, 100, STAT_SIZE);
			cmd(OP_WR, 256, 512, STAT_ALIGN);
			lock <= 1'b1;
			cmd(OP_WR, 512, 512, STAT_OK);
			cmd(OP_ER, 5, 40, STAT_OK);
			axi_rd(OFS_LAST);
			check("erase last", 32'd40, rd);
			cmd(OP_ER, 40, 5, STAT_SIZE);
			cmd(OP_DSR, 1, 0, STAT_NODSR);
			cmd(csdd_op_type'(3'h6), 0, 0, STAT_BADOP);
			axi_wr(OFS_REC0, 32'h0000_1000);
			cmd(OP_PUT, 0, 0, STAT_OK);
			check("temp", 32'h1, 32'(temp));
			cmd(OP_ER, 0, 0, STAT_PROT);
			axi_wr(OFS_REC0, 32'h0000_4800);
			cmd(OP_PUT, 0, 0, STAT_OK);
			cmd(OP_WR, 0, 512, STAT_OK);
			axi_rd(OFS_GEO);
			check("format", 32'h2, 32'(rd[29:28]));
			axi_wr(OFS_REC0, 32'h0000_2000);
			cmd(OP_PUT, 0, 0, STAT_OK);
			axi_rd(OFS_REC0);
			check("copy perm", 32'h6, 32'(rd[14:12]));
			cmd(OP_WR, 0, 512, STAT_PROT);
			check("perm", 32'h1, 32'(perm));
			axi_wr(OFS_REC0, 32'h0000_8000);
			cmd(OP_PUT, 0, 0, STAT_OK);
			axi_rd(OFS_STATUS);
			check("invalid", 32'h1, 32'(rd[2]));
			check("fault", 32'h0, 32'(fault));
			// Largest size exponent, written straight into the staging copy
			axi_wr(OFS_REC0 + 8'h04, 32'h0003_8000);
			check("bresp", 32'(RESP_OKAY), 32'(rs));
			axi_rd(OFS_FACT);
			check("fact max", 32'h0004_0200, rd);
			axi_rd(OFS_CAP);
			check("cap max", 32'h000F_A200, rd);
			axi_wr(8'h40, 32'h0000_0000);
			check("wr unmapped", 32'(RESP_SLV), 32'(rs));
			axi_rd(8'h40);
			check("unmapped", 32'(RESP_SLV), 32'(rs));
			rst_b_in <= 1'b0;
			lock <= 1'b0;
			repeat (2) @(posedge clk_in);
			rst_b_in <= 1'b1;
		end
	end
endmodule // tb_top
